// >>> common/tfs_defs.svh
/*
 Timing counts, status bit positions and reset values for the transceiver
 flag and status logic.
 Assumes a 10 MHz clock; filter times are plain defaults, not measured.
*/
`ifndef TFS_DEFS_SVH
`define TFS_DEFS_SVH

`define TFS_CLK_MHZ         10
// filter and timeout times in microseconds
`define TFS_T_DET_UV_US     20
`define TFS_T_DET_UV_CYC    (`TFS_T_DET_UV_US * `TFS_CLK_MHZ)
`define TFS_T_UVD_LP_US     100
`define TFS_T_UVD_LP_CYC    (`TFS_T_UVD_LP_US * `TFS_CLK_MHZ)
`define TFS_T_REC_UV_US     100
`define TFS_T_REC_UV_CYC    (`TFS_T_REC_UV_US * `TFS_CLK_MHZ)
`define TFS_T_CLAMP_US      300
`define TFS_T_CLAMP_CYC     (`TFS_T_CLAMP_US * `TFS_CLK_MHZ)
`define TFS_T_DET_EN_US     100
`define TFS_T_DET_EN_CYC    (`TFS_T_DET_EN_US * `TFS_CLK_MHZ)
`define TFS_CNT_W           12

// status bit positions
`define TFS_S_PIN_WAKE      0
`define TFS_S_LINE_WAKE     1
`define TFS_S_ONE           2
`define TFS_S_PWR_UP        3
`define TFS_S_MISMATCH      4
`define TFS_S_OVERHEAT      5
`define TFS_S_WARM          6
`define TFS_S_STUCK         7
`define TFS_S_BAT_LOW       8
`define TFS_S_CORE_LOW      9
`define TFS_S_IO_LOW        10
`define TFS_S_GUARD         11
`define TFS_S_ZERO          12
`define TFS_STATUS_W        13
`define TFS_STATUS_RST      13'h0004
`define TFS_BITCNT_W        4
`define TFS_LAST_BIT        4'hC

`endif

// >>> common/tfs_pkg.sv
/*
 Types shared by the transceiver flag and status logic.
 Assumes tfs_defs.svh is on the include path.
*/
`include "tfs_defs.svh"
package tfs_pkg;

   typedef enum logic [4:0] {
      TFS_NORMAL  = 5'b00001,
      TFS_RXONLY  = 5'b00010,
      TFS_STANDBY = 5'b00100,
      TFS_GOSLEEP = 5'b01000,
      TFS_SLEEP   = 5'b10000
   } tfs_mode_t;

   typedef struct packed {
      logic bat_low;
      logic core_low;
      logic io_low;
   } tfs_supply_t;

   typedef struct packed {
      logic pin_wakeup_source;
      logic line_wakeup_source;
      logic wake;
      logic power_up;
      logic warm_warning;
      logic overheat;
      logic tx_gate_stuck;
      logic line_mismatch;
   } tfs_flags_t;

endpackage

// >>> rtl/tfs_core.sv
/*
 Flag and status logic of a bus transceiver: supply-low overrides of the
 operating mode, wake, power-up, temperature, stuck-gate and mismatch
 flags, and a 13-bit status word read out serially on the fault pin with
 the mode pin as shift clock.
 Assumes all pin and comparator inputs are asynchronous and are
 synchronised here, except receive_data_i, which is used unsynchronised; power-on reset drives rst_i.
*/
`timescale 1ns/100ps
// Overview of operation
// - battery low forces sleep, regulator off
// - core supply low forces standby
// - io low filter forces inputs inactive
// - io supply low forces sleep
// - pin wake source set in low power
// - line wake needs battery in range
// - wake flag from sources, cleared on entry
// - power up flag cleared in normal
// - warm warning tracks medium temperature
// - overheat clears on gate falling edge
// - stuck gate flag after clamp time
// - mismatch when bus differs from transmit
// - mismatch clears on match or disable
// - battery low filtered, wake clears
// - core low uses mode dependent time
// - io low filtered, wake clears
// - fault low when S4 to S10 set
// - status shifted out on fault pin
// - readout needs io valid in high range, core valid in low range
// - idle after read clears stale bits
// - S0 S1 direct, S2 one, S12 zero
// - S3 to S10 latch, S11 guardian
// - standby, go-to-sleep, sleep are low power
// - wake flag drives outputs low in low power
module tfs_core
   import tfs_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic mode_ctrl_clock_pin_i,
   input  wire logic standby_select_n_pin_i,
   input  wire logic transmit_bit_in_i,
   input  wire logic tx_gate_n_i,
   input  wire logic guardian_gate_in_i,
   input  wire logic bus_data_i,
   input  wire logic valid_element_i,
   input  wire logic receive_data_i,
   input  wire logic bat_below_i,
   input  wire logic core_below_i,
   input  wire logic io_below_i,
   input  wire logic io_high_range_i,
   input  wire logic io_low_range_i,
   input  wire logic temp_medium_i,
   input  wire logic temp_high_i,
   input  wire logic pin_wake_event_i,
   input  wire logic line_wake_event_i,
   input  wire logic go_to_sleep_done_i,
   output logic      regulator_switch_out_o,
   output logic      fault_indicator_out_o,
   output logic      receive_bit_out_o,
   output logic      activity_out_n_o,
   output logic      transmitter_enable_o,
   output logic      transmit_data_o,
   output logic [4:0] mode_o
);
   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   localparam int NSYNC = 17;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic [NSYNC-1:0] raw_in;

   assign raw_in = {mode_ctrl_clock_pin_i, standby_select_n_pin_i,
                    transmit_bit_in_i, tx_gate_n_i, guardian_gate_in_i,
                    bus_data_i, valid_element_i, bat_below_i,
                    core_below_i, io_below_i, io_high_range_i,
                    io_low_range_i, temp_medium_i, temp_high_i,
                    pin_wake_event_i, line_wake_event_i,
                    go_to_sleep_done_i};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   logic s_clk_pin, s_stby_n, s_txd, s_gate_n, s_guard, s_bus, s_valid;
   logic s_bat, s_core, s_io, s_io_hi, s_io_lo, s_tmed, s_thigh;
   logic s_pwake, s_lwake, s_gts;
   assign {s_clk_pin, s_stby_n, s_txd, s_gate_n, s_guard, s_bus, s_valid,
           s_bat, s_core, s_io, s_io_hi, s_io_lo, s_tmed, s_thigh,
           s_pwake, s_lwake, s_gts} = sync_b;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic is_low_power(input tfs_mode_t m);
      return (m == TFS_STANDBY) || (m == TFS_GOSLEEP)
             || (m == TFS_SLEEP);
   endfunction

   function automatic tfs_mode_t pin_mode(input logic en, input logic sn);
      unique case ({en, sn})
         2'b11:   return TFS_NORMAL;
         2'b10:   return TFS_RXONLY;
         2'b01:   return TFS_GOSLEEP;
         default: return TFS_STANDBY;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      tfs_mode_t                  mode;
      tfs_flags_t                 fl;
      logic [`TFS_STATUS_W-1:0]   status;
      logic [`TFS_STATUS_W-1:0]   shift;
      logic [`TFS_BITCNT_W-1:0]   bit_idx;
      logic                       reading;
      logic                       read_done;
      logic [`TFS_CNT_W-1:0]      idle_cnt;
      logic [`TFS_CNT_W-1:0]      io_det_cnt;
      logic                       io_forced;
      logic [`TFS_CNT_W-1:0]      clamp_cnt;
      logic                       pin_q;
      logic                       gate_q;
      logic                       regulator;
      logic                       fault;
      logic                       rxd;
      logic                       activity_out_n_n;
      logic                       tx_en;
      logic                       tx_data;
   } tfs_state_t;

   tfs_state_t st;
   tfs_state_t next_st;
   tfs_supply_t uv;
   logic       wake_set;
   logic       lp_mode;

   assign lp_mode  = is_low_power(st.mode);
   assign wake_set = st.fl.pin_wakeup_source | st.fl.line_wakeup_source;

   // ------------------------------------------------------------------
   // supply filters
   // ------------------------------------------------------------------
   tfs_filter u_bat (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .low_i     (s_bat),
      .set_cnt_i (`TFS_CNT_W'(`TFS_T_DET_UV_CYC)),
      .clr_i     (wake_set),
      .flag_o    (uv.bat_low)
   );
   tfs_filter u_core (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .low_i     (s_core),
      .set_cnt_i (lp_mode ? `TFS_CNT_W'(`TFS_T_UVD_LP_CYC)
                          : `TFS_CNT_W'(`TFS_T_DET_UV_CYC)),
      .clr_i     (wake_set),
      .flag_o    (uv.core_low)
   );
   tfs_filter u_io (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .low_i     (s_io),
      .set_cnt_i (`TFS_CNT_W'(`TFS_T_UVD_LP_CYC)),
      .clr_i     (wake_set),
      .flag_o    (uv.io_low)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   logic      en_eff, sn_eff, txd_eff, guard_eff, gate_n_eff;
   logic      enter_lp, any_uv, uv_rise, readable, shift_edge;
   tfs_mode_t want;
   tfs_supply_t uv_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         uv_q <= '0;
      end else begin
         uv_q <= uv;
      end
   end

   always_comb begin
      next_st = st;
      // io filter forces inputs inactive regardless of flag
      if (s_io) begin
         if (st.io_det_cnt + 1'b1 >= `TFS_CNT_W'(`TFS_T_DET_UV_CYC)) begin
            next_st.io_forced = 1'b1;
         end else begin
            next_st.io_det_cnt = st.io_det_cnt + 1'b1;
         end
      end else begin
         next_st.io_det_cnt = '0;
         next_st.io_forced  = 1'b0;
      end
      en_eff     = s_clk_pin & ~st.io_forced;
      sn_eff     = s_stby_n  & ~st.io_forced;
      txd_eff    = s_txd     & ~st.io_forced;
      guard_eff  = s_guard   & ~st.io_forced;
      gate_n_eff = s_gate_n  |  st.io_forced;

      any_uv  = uv.bat_low | uv.core_low | uv.io_low;
      uv_rise = |(uv & ~uv_q);

      // mode selection with supply overrides
      want = pin_mode(en_eff, sn_eff);
      if (uv.bat_low || uv.io_low) begin
         want = TFS_SLEEP;
      end else if (uv.core_low) begin
         want = TFS_STANDBY;
      end else if (want == TFS_GOSLEEP && s_gts && !st.fl.wake) begin
         want = TFS_SLEEP;
      end else if (st.mode == TFS_SLEEP && !st.fl.wake
                   && want == TFS_GOSLEEP) begin
         want = TFS_SLEEP;
      end
      next_st.mode = want;
      enter_lp = is_low_power(want) && !lp_mode;

      // wake sources and wake flag
      if (lp_mode && s_pwake) begin
         next_st.fl.pin_wakeup_source = 1'b1;
      end else if (enter_lp) begin
         next_st.fl.pin_wakeup_source = 1'b0;
      end
      if (lp_mode && !s_bat && s_lwake) begin
         next_st.fl.line_wakeup_source = 1'b1;
      end else if (enter_lp) begin
         next_st.fl.line_wakeup_source = 1'b0;
      end
      if (wake_set) begin
         next_st.fl.wake = 1'b1;
      end else if (enter_lp || uv_rise) begin
         next_st.fl.wake = 1'b0;
      end

      if (want == TFS_NORMAL) begin
         next_st.fl.power_up = 1'b0;
      end

      // temperature
      next_st.gate_q = gate_n_eff;
      if (!lp_mode) begin
         next_st.fl.warm_warning = s_tmed;
         if (s_thigh) begin
            next_st.fl.overheat = 1'b1;
         end else if (st.gate_q && !gate_n_eff) begin
            next_st.fl.overheat = 1'b0;
         end
      end

      // clamp detection
      if (gate_n_eff) begin
         next_st.clamp_cnt        = '0;
         next_st.fl.tx_gate_stuck = 1'b0;
      end else if (st.clamp_cnt + 1'b1 >= `TFS_CNT_W'(`TFS_T_CLAMP_CYC))
      begin
         next_st.fl.tx_gate_stuck = 1'b1;
      end else begin
         next_st.clamp_cnt = st.clamp_cnt + 1'b1;
      end

      next_st.tx_en = (st.mode == TFS_NORMAL) && guard_eff && !gate_n_eff
                      && !st.fl.overheat && !st.fl.tx_gate_stuck;
      next_st.tx_data = txd_eff;

      // mismatch, no action taken
      if (!st.tx_en || s_bus == txd_eff) begin
         next_st.fl.line_mismatch = 1'b0;
      end else if (!s_valid) begin
         next_st.fl.line_mismatch = 1'b1;
      end

      // status latch
      next_st.status[`TFS_S_PIN_WAKE]  = st.fl.pin_wakeup_source;
      next_st.status[`TFS_S_LINE_WAKE] = st.fl.line_wakeup_source;
      next_st.status[`TFS_S_ONE]       = 1'b1;
      next_st.status[`TFS_S_ZERO]      = 1'b0;
      next_st.status[`TFS_S_GUARD]     = guard_eff;
      next_st.status[`TFS_S_IO_LOW:`TFS_S_PWR_UP] =
         st.status[`TFS_S_IO_LOW:`TFS_S_PWR_UP]
         | {uv.io_low, uv.core_low, uv.bat_low, st.fl.tx_gate_stuck,
            st.fl.warm_warning, st.fl.overheat, st.fl.line_mismatch,
            st.fl.power_up};

      // serial readout
      readable = (!uv.io_low && s_io_hi) || (!uv.core_low && s_io_lo);
      next_st.pin_q = s_clk_pin;
      shift_edge    = s_clk_pin != st.pin_q;
      if (shift_edge && readable) begin
         next_st.idle_cnt = '0;
         if (!st.reading) begin
            next_st.reading = 1'b1;
            next_st.shift   = st.status;
            next_st.bit_idx = '0;
         end else if (st.bit_idx != `TFS_LAST_BIT) begin
            next_st.bit_idx = st.bit_idx + 1'b1;
            next_st.shift   = st.shift >> 1;
            if (st.bit_idx + 1'b1 == `TFS_LAST_BIT) begin
               next_st.read_done = 1'b1;
            end
         end
      end else if (st.reading) begin
         if (st.idle_cnt + 1'b1 >= `TFS_CNT_W'(`TFS_T_DET_EN_CYC)) begin
            next_st.reading  = 1'b0;
            next_st.idle_cnt = '0;
            if (st.read_done) begin
               next_st.read_done = 1'b0;
               // clear stale bits S4..S10 whose flag has reset
               next_st.status[`TFS_S_IO_LOW:`TFS_S_MISMATCH] =
                  st.status[`TFS_S_IO_LOW:`TFS_S_MISMATCH]
                  & {uv.io_low, uv.core_low, uv.bat_low,
                     st.fl.tx_gate_stuck, st.fl.warm_warning,
                     st.fl.overheat, st.fl.line_mismatch};
               if (lp_mode && !s_tmed) begin
                  next_st.fl.warm_warning = 1'b0;
               end
            end
         end else begin
            next_st.idle_cnt = st.idle_cnt + 1'b1;
         end
      end

      // pin outputs
      next_st.regulator = (want != TFS_SLEEP);
      if (is_low_power(want) && st.fl.wake) begin
         next_st.fault  = 1'b0;
         next_st.rxd    = 1'b0;
         next_st.activity_out_n_n = 1'b0;
      end else begin
         next_st.rxd    = is_low_power(want) ? 1'b1 : receive_data_i;
         next_st.activity_out_n_n = is_low_power(want) ? 1'b1 : s_bus;
         if (next_st.reading) begin
            next_st.fault = next_st.shift[0];
         end else begin
            next_st.fault =
               ~|st.status[`TFS_S_IO_LOW:`TFS_S_MISMATCH];
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st           <= '0;
         st.mode      <= TFS_STANDBY;
         st.fl.power_up <= 1'b1;
         st.status    <= `TFS_STATUS_RST;
         st.regulator <= 1'b1;
         st.fault     <= 1'b1;
         st.rxd       <= 1'b1;
         st.activity_out_n_n    <= 1'b1;
         st.pin_q     <= 1'b0;
         st.gate_q    <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign regulator_switch_out_o = st.regulator;
   assign fault_indicator_out_o  = st.fault;
   assign receive_bit_out_o      = st.rxd;
   assign activity_out_n_o       = st.activity_out_n_n;
   assign transmitter_enable_o   = st.tx_en;
   assign transmit_data_o        = st.tx_data;
   assign mode_o                 = st.mode;
endmodule

// >>> rtl/tfs_filter.sv
/*
 Timed level filter for a supply comparator: sets its flag after the
 input stays low for a set time, clears after it stays high for a
 recovery time or on a clear request, unless its set time completes in the same cycle.
 Assumes a synchronised comparator input on the same clock.
*/
`timescale 1ns/100ps
module tfs_filter
   import tfs_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  low_i,
   input  wire logic [`TFS_CNT_W-1:0] set_cnt_i,
   input  wire logic                  clr_i,
   output logic                       flag_o
);
   typedef struct packed {
      logic [`TFS_CNT_W-1:0] cnt;
      logic                  flag;
   } tfs_flt_st_t;

   tfs_flt_st_t st;
   tfs_flt_st_t next_st;

   always_comb begin
      next_st = st;
      if (low_i == st.flag) begin
         next_st.cnt = '0;
      end else if (!st.flag && st.cnt + 1'b1 >= set_cnt_i) begin
         next_st.flag = 1'b1;
         next_st.cnt  = '0;
      end else if (st.flag &&
                   st.cnt + 1'b1 >= `TFS_CNT_W'(`TFS_T_REC_UV_CYC)) begin
         next_st.flag = 1'b0;
         next_st.cnt  = '0;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
      if (clr_i && !(low_i && !st.flag && next_st.flag)) begin
         next_st.flag = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flag_o = st.flag;
endmodule

// >>> verification/tfs_core_chk.sv
/*
 Checker for tfs_core: mode, regulator, transmitter and reset relations.
 Assumes the bind below and the fixed times of tfs_defs.svh.
*/
`timescale 1ns/100ps
module tfs_core_chk
   import tfs_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       tx_gate_n_i,
   input wire logic       bat_below_i,
   input wire logic       core_below_i,
   input wire logic       io_below_i,
   input wire logic       temp_high_i,
   input wire logic       pin_wake_event_i,
   input wire logic       line_wake_event_i,
   input wire logic       regulator_switch_out_o,
   input wire logic       fault_indicator_out_o,
   input wire logic       transmitter_enable_o,
   input wire logic [4:0] mode_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // run-length counters of the inputs
   // ----------------------------------------
   logic [11:0] bat_cnt;
   logic [11:0] core_cnt;
   logic [11:0] io_cnt;
   logic [11:0] tx_cnt;
   logic        no_wake;

   function automatic logic [11:0] step(input logic [11:0] c,
                                        input logic        en);
      return !en ? 12'h000 : (c == 12'hFFF) ? c : c + 12'h001;
   endfunction

   assign no_wake = !pin_wake_event_i && !line_wake_event_i;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bat_cnt  <= 12'h000;
         core_cnt <= 12'h000;
         io_cnt   <= 12'h000;
         tx_cnt   <= 12'h000;
      end else begin
         bat_cnt  <= step(bat_cnt, bat_below_i && no_wake);
         core_cnt <= step(core_cnt, core_below_i && no_wake);
         io_cnt   <= step(io_cnt, io_below_i && no_wake);
         tx_cnt   <= step(tx_cnt, !tx_gate_n_i);
      end
   end

   rst_vals_a: assert property (disable iff (1'b0)
      rst_i && $past(rst_i) |-> mode_o == 5'h04 && regulator_switch_out_o
      && fault_indicator_out_o && !transmitter_enable_o)
      else $error("reset values wrong");
   sleep_reg_a: assert property (
      mode_o == 5'h10 && $past(mode_o) == 5'h10 |-> !regulator_switch_out_o)
      else $error("regulator on in sleep");
   lp_tx_off_a: assert property (
      !mode_o[0] && !$past(mode_o[0]) |-> !transmitter_enable_o)
      else $error("transmitter on outside normal");
   bat_sleep_a: assert property (
      bat_cnt == 12'h0D2 |-> mode_o == 5'h10)
      else $error("no sleep on battery low");
   core_stby_a: assert property (
      core_cnt == 12'h3F2 && mode_o != 5'h10 |-> mode_o == 5'h04)
      else $error("no standby on core low");
   io_force_a: assert property (
      io_cnt == 12'h0D2 |-> mode_o inside {5'h04, 5'h10}
      && !transmitter_enable_o)
      else $error("inputs not forced on io low");
   io_sleep_a: assert property (
      io_cnt == 12'h3F2 |-> mode_o == 5'h10 && !regulator_switch_out_o)
      else $error("no sleep on io low");
   clamp_off_a: assert property (
      tx_cnt >= 12'hBC2 |-> !transmitter_enable_o)
      else $error("transmitter on with gate stuck");
   hot_off_a: assert property (
      temp_high_i [*6] |-> !transmitter_enable_o)
      else $error("transmitter on while hot");

   cover property (mode_o == 5'h10 ##1 mode_o == 5'h04);
   cover property (transmitter_enable_o ##1 !transmitter_enable_o);
   cover property ($fell(fault_indicator_out_o));
endmodule

bind tfs_core tfs_core_chk u_chk (
   .clk_i, .rst_i, .tx_gate_n_i, .bat_below_i, .core_below_i, .io_below_i,
   .temp_high_i, .pin_wake_event_i, .line_wake_event_i,
   .regulator_switch_out_o, .fault_indicator_out_o, .transmitter_enable_o,
   .mode_o
);

// >>> verification/tfs_core_tb.sv
/*
 Testbench for tfs_core: drives pins and comparators, reads status words
 through the host model, checks modes, gates and the fault pin.
 Assumes the fixed times of tfs_defs.svh and tfs_host_mdl.
*/
`timescale 1ns/100ps
module tfs_core_tb;
   import tfs_pkg::*;

   logic        clk_i, rst_i, mode_ctrl_clock_pin_i, standby_select_n_pin_i;
   logic        transmit_bit_in_i, tx_gate_n_i, guardian_gate_in_i;
   logic        bus_data_i, valid_element_i, receive_data_i, bat_below_i;
   logic        core_below_i, io_below_i, io_high_range_i, io_low_range_i;
   logic        temp_medium_i, temp_high_i, pin_wake_event_i;
   logic        line_wake_event_i, go_to_sleep_done_i;
   logic        regulator_switch_out_o, fault_indicator_out_o;
   logic        receive_bit_out_o, activity_out_n_o, transmitter_enable_o;
   logic        transmit_data_o, sel, start, busy;
   logic [4:0]  mode_o;
   logic [12:0] word;
   int          num_errors, samples_checked, cycles;

   tfs_core dut (.*);
   tfs_host_mdl host (.clk_i, .sel_i(sel), .start_i(start),
      .fault_i(fault_indicator_out_o), .mode_pin_o(mode_ctrl_clock_pin_i),
      .busy_o(busy), .word_o(word));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic pins(input logic [1:0] v);
      {sel, standby_select_n_pin_i} = v;
      cyc(10);
   endtask
   task automatic do_read(input logic [12:0] exp);
      int n;
      n = 0;
      cyc(1100);
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      while (busy !== 1'b0 && n < 300) begin
         cyc(1);
         n++;
      end
      chk(word, exp);
   endtask
   task automatic end_sim;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         end_sim();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reads;
      chk(13'(mode_o), 13'h0004);
      chk({8'h00, regulator_switch_out_o, fault_indicator_out_o,
           receive_bit_out_o, activity_out_n_o, transmitter_enable_o},
          13'h001E);
      io_high_range_i = 1'b0;
      do_read(13'h1FFF);
      io_high_range_i = 1'b1;
      do_read(13'h000C);
      guardian_gate_in_i = 1'b1;
      cyc(4);
      do_read(13'h080C);
      guardian_gate_in_i = 1'b0;
   endtask
   task automatic t_warm;
      pins(2'b11);
      chk(13'(mode_o), 13'h0001);
      cyc(1100);
      temp_medium_i = 1'b1;
      cyc(10);
      temp_medium_i = 1'b0;
      cyc(10);
      chk(13'(fault_indicator_out_o), 13'h0000);
      pins(2'b00);
      do_read(13'h004C);
      cyc(1100);
      chk(13'(fault_indicator_out_o), 13'h0001);
   endtask
   task automatic t_mismatch;
      {guardian_gate_in_i, transmit_bit_in_i, valid_element_i} = 3'h7;
      bus_data_i = 1'b0;
      tx_gate_n_i = 1'b0;
      pins(2'b11);
      cyc(1100);
      chk(13'(fault_indicator_out_o), 13'h0001);
      valid_element_i = 1'b0;
      cyc(10);
      chk(13'(fault_indicator_out_o), 13'h0000);
      bus_data_i = 1'b1;
      cyc(10);
      {tx_gate_n_i, guardian_gate_in_i} = 2'b10;
      pins(2'b00);
      do_read(13'h001C);
      cyc(1100);
      chk(13'(fault_indicator_out_o), 13'h0001);
   endtask
   task automatic t_supply;
      bat_below_i = 1'b1;
      cyc(300);
      chk({7'h00, regulator_switch_out_o, mode_o}, 13'h0010);
      bat_below_i = 1'b0;
      cyc(1100);
      chk(13'(mode_o), 13'h0004);
      do_read(13'h010C);
      cyc(1100);
      chk(13'(fault_indicator_out_o), 13'h0001);
      pins(2'b11);
      core_below_i = 1'b1;
      cyc(250);
      chk(13'(mode_o), 13'h0004);
      core_below_i = 1'b0;
      cyc(1100);
      chk(13'(mode_o), 13'h0001);
      io_below_i = 1'b1;
      cyc(250);
      chk(13'(mode_o), 13'h0004);
      cyc(850);
      chk({7'h00, regulator_switch_out_o, mode_o}, 13'h0010);
      io_below_i = 1'b0;
      cyc(1100);
      chk(13'(mode_o), 13'h0001);
   endtask
   task automatic t_gate;
      {guardian_gate_in_i, transmit_bit_in_i, bus_data_i} = 3'h4;
      tx_gate_n_i = 1'b0;
      cyc(20);
      chk(13'(transmitter_enable_o), 13'h0001);
      temp_high_i = 1'b1;
      cyc(10);
      temp_high_i = 1'b0;
      cyc(10);
      chk(13'(transmitter_enable_o), 13'h0000);
      tx_gate_n_i = 1'b1;
      cyc(5);
      tx_gate_n_i = 1'b0;
      cyc(10);
      chk(13'(transmitter_enable_o), 13'h0001);
      cyc(3100);
      chk(13'(transmitter_enable_o), 13'h0000);
      tx_gate_n_i = 1'b1;
      cyc(5);
      tx_gate_n_i = 1'b0;
      cyc(10);
      chk(13'(transmitter_enable_o), 13'h0001);
      tx_gate_n_i = 1'b1;
   endtask
   task automatic t_wake;
      pins(2'b00);
      chk({11'h000, receive_bit_out_o, activity_out_n_o}, 13'h0003);
      pin_wake_event_i = 1'b1;
      cyc(10);
      pin_wake_event_i = 1'b0;
      cyc(5);
      chk({10'h000, receive_bit_out_o, activity_out_n_o,
           fault_indicator_out_o}, 13'h0000);
   endtask

   initial begin
      {sel, start, standby_select_n_pin_i, transmit_bit_in_i, bus_data_i,
       valid_element_i, bat_below_i, core_below_i, io_below_i,
       io_low_range_i, temp_medium_i, temp_high_i, pin_wake_event_i,
       line_wake_event_i, go_to_sleep_done_i, guardian_gate_in_i} = 16'h0;
      {rst_i, tx_gate_n_i, io_high_range_i, receive_data_i} = 4'hF;
      num_errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      cyc(5);
      t_reads();
      t_warm();
      t_mismatch();
      t_supply();
      t_gate();
      t_wake();
      end_sim();
   end
endmodule

// >>> verification/tfs_host_mdl.sv
/*
 Host model: reads the status word by toggling the mode pin 14 times.
 Assumes edges 10 cycles apart and fault settled 5 cycles after an edge.
*/
`timescale 1ns/100ps
module tfs_host_mdl (
   input  wire logic   clk_i,
   input  wire logic   sel_i,
   input  wire logic   start_i,
   input  wire logic   fault_i,
   output logic        mode_pin_o,
   output logic        busy_o,
   output logic [12:0] word_o
);
   logic flip;

   assign mode_pin_o = sel_i ^ flip;
   initial begin
      flip = 1'b0;
      busy_o = 1'b0;
      word_o = 13'h0000;
      forever begin
         @(posedge clk_i);
         if (start_i) begin
            busy_o = 1'b1;
            // ------------------------------------
            // 13 bits, then one edge to restore
            // ------------------------------------
            for (int i = 0; i < 14; i++) begin
               #1 flip = ~flip;
               repeat (5) @(posedge clk_i);
               if (i < 13) word_o[i] = fault_i;
               repeat (5) @(posedge clk_i);
            end
            busy_o = 1'b0;
         end
      end
   end
endmodule
